/* File: dasc_pkg.sv */
// Constants and types for the dual converter serial mode control block
package dasc_pkg;
  localparam int CLK_PERIOD_NS = 5;

  // Positions in the synchronised pin vector
  localparam int PIN_CLK  = 0;
  localparam int PIN_TRIG = 1;
  localparam int PIN_RD   = 2;
  localparam int PIN_SDI  = 3;
  localparam int PIN_AUTO = 4;
  localparam int PIN_SGL  = 5;
  localparam int NPIN     = 6;

  // Configuration word, first bit shifted in lands in bit 11
  localparam int CFG_W      = 12;
  localparam int CFG_CHAN_H = 11;
  localparam int CFG_FEAT_H = 9;
  localparam int CFG_FEAT_L = 8;
  localparam int CFG_CMD_H  = 7;
  localparam int CFG_CMD_L  = 5;
  localparam int CFG_DEEP   = 4;
  localparam int CFG_NAP    = 3;
  localparam int CFG_AN     = 2;
  localparam int CFG_REFOFF = 1;
  localparam int CFG_DUAL   = 0;
  localparam int DAC_W      = 10;

  localparam logic [1:0]       FEAT_UPDATE = 2'h1;
  localparam logic [2:0]       CMD_DAC_WR  = 3'h1;
  localparam logic [2:0]       CMD_DAC_RD  = 3'h3;
  localparam logic [2:0]       CMD_RESET   = 3'h5;
  localparam logic [DAC_W-1:0] DAC_RESET   = 10'h3ff;

  // Counts of converter clock edges
  localparam logic [3:0] CFG_EDGE      = 4'hc;
  localparam logic [3:0] CHAN_EDGE     = 4'h2;
  localparam logic [4:0] CONV_CLKS     = 5'h10;
  localparam int         NAP_WAKE_CLKS = 3;

  // Times and their counts of MCLK cycles
  localparam int DEEP_OFF_NS  = 2000;
  localparam int DEEP_WAKE_NS = 1000;
  localparam int NAP_OFF_NS   = 200;
  localparam int RESET_NS     = 500;
  localparam int DEEP_OFF_CYC  = DEEP_OFF_NS / CLK_PERIOD_NS;
  localparam int DEEP_WAKE_CYC = DEEP_WAKE_NS / CLK_PERIOD_NS;
  localparam int NAP_OFF_CYC   = NAP_OFF_NS / CLK_PERIOD_NS;
  localparam int RESET_CYC     = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // APB map
  localparam logic [7:0] ADDR_SAMPLE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;

  typedef enum logic [1:0] {PW_ON, PW_FALL, PW_OFF, PW_WAKE} dasc_pwr_e;

  typedef struct packed {
    logic [NPIN-1:0]  s1, s2, s3, pin;
    logic             clk_d, trig_d, rd_d;
    logic [CFG_W-1:0] cfg, sh_in;
    logic [3:0]       rise_cnt;
    logic             acc_on, dac_wr_arm, dac_rd_arm, dac_wr_now, dac_rd_now;
    logic             pend_v, pend_rst;
    logic [2:0]       pend_pwr;
    logic [DAC_W-1:0] dac;
    logic [1:0]       chan;
    logic             conv_on, conv_pend, an_sleep, pair, res_pair, half;
    logic [4:0]       conv_cnt;
    logic [11:0]      res_a, res_b, samp_a, samp_b;
    logic [31:0]      sh_a;
    logic [15:0]      sh_b;
    logic             out_a, out_b, b_oe, analog_on, deep_mode;
    dasc_pwr_e        pwr;
    logic [8:0]       pwr_cnt, rst_cnt;
    logic [31:0]      prdata;
    logic             pready, pslverr;
  } dasc_state_s;
endpackage

/* File: dasc_top.sv */
// Serial mode control and readout logic of the dual sampling converter
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module dasc_top (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        CONV_CLK,
  input  wire logic        SAMPLE_TRIGGER,
  input  wire logic        READ_STROBE,
  input  wire logic        CONFIG_SERIAL_IN,
  input  wire logic        CHAN_AUTO_PIN,
  input  wire logic        SINGLE_OUTPUT_PIN,
  output logic             RESULT_LINE_A,
  output logic             RESULT_LINE_B,
  output logic             RESULT_LINE_B_OE,
  output logic             BUSY,
  output logic             ANALOG_ACTIVE,
  output logic             REF_POWER_OFF,
  output logic      [9:0]  REF_DAC_CODE
);

  function automatic dasc_pkg::dasc_state_s init_st();
    dasc_pkg::dasc_state_s s;
    s = '0;
    s.dac = dasc_pkg::DAC_RESET;
    s.b_oe = 1'b1;
    s.analog_on = 1'b1;
    s.pwr = dasc_pkg::PW_ON;
    return s;
  endfunction

  localparam dasc_pkg::dasc_state_s ST_INIT = init_st();

  dasc_pkg::dasc_state_s        st;
  dasc_pkg::dasc_state_s        n;
  logic [dasc_pkg::NPIN-1:0]    pins_raw;
  logic [dasc_pkg::NPIN-1:0]    pin_next;
  logic                         fall;
  logic                         rise;
  logic                         trig_rise;
  logic                         rd_rise;
  logic                         live;
  logic                         auto_m;
  logic                         sgl;
  logic                         conv_done;
  logic                         sleep_req;
  logic [15:0]                  frame_a;
  logic [15:0]                  frame_b;
  logic [dasc_pkg::CFG_W-1:0]   word;

  assign pins_raw = {SINGLE_OUTPUT_PIN, CHAN_AUTO_PIN, CONFIG_SERIAL_IN,
                     READ_STROBE, SAMPLE_TRIGGER, CONV_CLK};

  ////////////////////////////////////////////////////////////////////////////
  // Pin qualification: a change counts once stages two and three agree
  for (genvar i = 0; i < dasc_pkg::NPIN; i++) begin : g_sync
    assign pin_next[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.pin[i];
  end

  assign fall      = st.clk_d & ~st.pin[dasc_pkg::PIN_CLK];
  assign rise      = ~st.clk_d & st.pin[dasc_pkg::PIN_CLK];
  assign trig_rise = ~st.trig_d & st.pin[dasc_pkg::PIN_TRIG];
  assign rd_rise   = ~st.rd_d & st.pin[dasc_pkg::PIN_RD];
  assign live      = (st.rst_cnt == '0);
  assign auto_m    = st.pin[dasc_pkg::PIN_AUTO];
  assign sgl       = st.pin[dasc_pkg::PIN_SGL];
  assign conv_done = fall & st.conv_on & (st.conv_cnt == dasc_pkg::CONV_CLKS - 5'h1);
  assign sleep_req = st.cfg[dasc_pkg::CFG_DEEP] | st.cfg[dasc_pkg::CFG_NAP] | st.an_sleep;
  assign word      = {st.sh_in[dasc_pkg::CFG_W-2:0], st.pin[dasc_pkg::PIN_SDI]};

  // Frame headers; MSB first, result kept in twos complement
  assign frame_a = {auto_m & st.res_pair, 1'b0, st.res_a, 2'b00};
  assign frame_b = {auto_m & st.res_pair, sgl, st.res_b, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    n = st;
    n.s1 = pins_raw;
    n.s2 = st.s1;
    n.s3 = st.s2;
    n.pin = pin_next;
    n.clk_d = st.pin[dasc_pkg::PIN_CLK];
    n.trig_d = st.pin[dasc_pkg::PIN_TRIG];
    n.rd_d = st.pin[dasc_pkg::PIN_RD];
    n.pready = 1'b0;

    // APB slave: one wait state, error on unmapped offsets
    if (PSEL && PENABLE && !st.pready) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = '0;
      case (PADDR)
        dasc_pkg::ADDR_SAMPLE: begin
          if (PWRITE) begin
            n.samp_a = PWDATA[11:0];
            n.samp_b = PWDATA[27:16];
          end
          n.prdata = {4'h0, st.samp_b, 4'h0, st.samp_a};
        end
        dasc_pkg::ADDR_STATUS: begin
          n.prdata = {4'h0, st.chan, st.dac, 8'h0, ~live, st.b_oe, st.res_pair,
                      st.half, st.an_sleep, st.conv_on, st.pwr};
        end
        dasc_pkg::ADDR_CONFIG: begin
          n.prdata = {20'h0, st.cfg};
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
    end

    if (!sgl) begin
      n.b_oe = 1'b1;
    end

    if (!live) begin
      // Serial side ignores all pins but the single output pin (line B enable) while the device reset runs out
      n.rst_cnt = st.rst_cnt - 9'h1;
    end else begin
      // Power sequencing; register contents stay untouched
      case (st.pwr)
        dasc_pkg::PW_ON: begin
          if (sleep_req) begin
            n.pwr = dasc_pkg::PW_FALL;
            n.deep_mode = st.cfg[dasc_pkg::CFG_DEEP];
            n.pwr_cnt = st.cfg[dasc_pkg::CFG_DEEP] ?
                        9'(dasc_pkg::DEEP_OFF_CYC) : 9'(dasc_pkg::NAP_OFF_CYC);
          end
        end
        dasc_pkg::PW_FALL: begin
          if (!sleep_req) begin
            n.pwr = dasc_pkg::PW_ON;
          end else if (st.pwr_cnt == '0) begin
            n.pwr = dasc_pkg::PW_OFF;
            n.analog_on = 1'b0;
          end else begin
            n.pwr_cnt = st.pwr_cnt - 9'h1;
          end
        end
        dasc_pkg::PW_OFF: begin
          if (!sleep_req) begin
            n.pwr = dasc_pkg::PW_WAKE;
            n.pwr_cnt = st.deep_mode ?
                        9'(dasc_pkg::DEEP_WAKE_CYC) : 9'(dasc_pkg::NAP_WAKE_CLKS);
          end
        end
        dasc_pkg::PW_WAKE: begin
          if (st.pwr_cnt == '0) begin
            n.pwr = dasc_pkg::PW_ON;
            n.analog_on = 1'b1;
          end else if (st.deep_mode || fall) begin
            n.pwr_cnt = st.pwr_cnt - 9'h1;
          end
        end
        default: begin
          n.pwr = dasc_pkg::PW_ON;
        end
      endcase

      // Trigger: ignored in deep or nap, wakes from auto-nap
      if (trig_rise && !st.cfg[dasc_pkg::CFG_DEEP] && !st.cfg[dasc_pkg::CFG_NAP]) begin
        n.conv_pend = 1'b1;
        n.an_sleep = 1'b0;
      end
      if (st.conv_pend && !st.conv_on && st.pwr == dasc_pkg::PW_ON && !sleep_req) begin
        n.conv_on = 1'b1;
        n.conv_pend = 1'b0;
        n.conv_cnt = '0;
      end

      // Configuration capture on rising edges
      if (rise && st.acc_on) begin
        n.sh_in = word;
        n.rise_cnt = st.rise_cnt + 4'h1;
        if (n.rise_cnt == dasc_pkg::CFG_EDGE) begin
          n.acc_on = 1'b0;
          n.dac_wr_now = 1'b0;
          n.dac_rd_now = 1'b0;
          if (st.dac_wr_now) begin
            n.dac = word[dasc_pkg::DAC_W-1:0];
          end else if (!st.dac_rd_now) begin
            if (word[dasc_pkg::CFG_FEAT_H:dasc_pkg::CFG_FEAT_L] == dasc_pkg::FEAT_UPDATE) begin
              // Features act here, power flags wait for the falling edge
              n.cfg[dasc_pkg::CFG_W-1:dasc_pkg::CFG_CMD_L] =
                word[dasc_pkg::CFG_W-1:dasc_pkg::CFG_CMD_L];
              n.cfg[dasc_pkg::CFG_REFOFF] = word[dasc_pkg::CFG_REFOFF];
              n.cfg[dasc_pkg::CFG_DUAL] = word[dasc_pkg::CFG_DUAL];
              n.pend_v = 1'b1;
              n.pend_pwr = word[dasc_pkg::CFG_DEEP:dasc_pkg::CFG_AN];
              n.dac_wr_arm = (word[dasc_pkg::CFG_CMD_H:dasc_pkg::CFG_CMD_L] ==
                              dasc_pkg::CMD_DAC_WR);
              n.dac_rd_arm = (word[dasc_pkg::CFG_CMD_H:dasc_pkg::CFG_CMD_L] ==
                              dasc_pkg::CMD_DAC_RD);
            end
            n.pend_rst = (word[dasc_pkg::CFG_CMD_H:dasc_pkg::CFG_CMD_L] ==
                          dasc_pkg::CMD_RESET);
          end
        end
      end

      if (fall) begin
        n.out_a = st.sh_a[31];
        n.out_b = st.sh_b[15];
        n.sh_a = {st.sh_a[30:0], 1'b0};
        n.sh_b = {st.sh_b[14:0], 1'b0};
        // Static input over the first clocks selects the pair
        if (st.acc_on && st.rise_cnt == dasc_pkg::CHAN_EDGE) begin
          n.chan = st.sh_in[1:0];
        end
        if (st.conv_on) begin
          n.conv_cnt = st.conv_cnt + 5'h1;
        end
        if (conv_done) begin
          n.conv_on = 1'b0;
          n.res_a = st.samp_a;
          n.res_b = st.samp_b;
          // Channel bits count only in manual mode
          n.res_pair = auto_m ? st.pair : st.chan[1];
          n.pair = auto_m ? ~st.pair : st.pair;
          n.half = 1'b0;
          n.an_sleep = st.cfg[dasc_pkg::CFG_AN];
          if (sgl) begin
            n.b_oe = ~auto_m & st.cfg[dasc_pkg::CFG_DUAL];
          end
        end
        if (st.pend_v) begin
          n.pend_v = 1'b0;
          n.cfg[dasc_pkg::CFG_DEEP:dasc_pkg::CFG_AN] = st.pend_pwr;
          if (st.pend_pwr[2] || st.pend_pwr[1]) begin
            n.conv_on = 1'b0;
            n.conv_pend = 1'b0;
          end
        end
      end

      // Read strobe: load frames and open a configuration access
      if (rd_rise) begin
        n.acc_on = 1'b1;
        n.rise_cnt = '0;
        n.sh_in = '0;
        n.dac_wr_now = st.dac_wr_arm;
        n.dac_wr_arm = 1'b0;
        n.sh_b = frame_b;
        if (st.dac_rd_arm) begin
          n.sh_a = {4'h0, st.dac, 2'b00, 16'h0};
          n.dac_rd_arm = 1'b0;
          n.dac_rd_now = 1'b1;
        end else if (sgl && st.cfg[dasc_pkg::CFG_DUAL]) begin
          n.sh_a = {frame_a, frame_b};
        end else if (sgl) begin
          n.sh_a = {st.half ? frame_b : frame_a, 16'h0};
          n.half = ~st.half;
        end else begin
          n.sh_a = {frame_a, 16'h0};
        end
      end

      // Device reset after the 12th falling edge of the access
      if (fall && st.pend_rst) begin
        n = ST_INIT;
        n.s1 = pins_raw;
        n.s2 = st.s1;
        n.s3 = st.s2;
        n.pin = pin_next;
        n.clk_d = st.pin[dasc_pkg::PIN_CLK];
        n.trig_d = st.pin[dasc_pkg::PIN_TRIG];
        n.rd_d = st.pin[dasc_pkg::PIN_RD];
        n.samp_a = st.samp_a;
        n.samp_b = st.samp_b;
        n.prdata = st.prdata;
        n.pslverr = st.pslverr;
        n.pready = (PSEL && PENABLE && !st.pready);
        n.rst_cnt = 9'(dasc_pkg::RESET_CYC);
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st <= ST_INIT;
    end else if (CE) begin
      st <= n;
    end
  end

  assign PRDATA           = st.prdata;
  assign PREADY           = st.pready;
  assign PSLVERR          = st.pslverr;
  assign RESULT_LINE_A    = st.out_a;
  assign RESULT_LINE_B    = st.out_b;
  assign RESULT_LINE_B_OE = st.b_oe;
  assign BUSY             = st.conv_on;
  assign ANALOG_ACTIVE    = st.analog_on;
  assign REF_POWER_OFF    = st.cfg[dasc_pkg::CFG_REFOFF];
  assign REF_DAC_CODE     = st.dac;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  auto_pair_a: assert property (CE && conv_done && live && auto_m |=>
    st.pair != $past(st.pair)) else $error("pair did not alternate");
  frame3_hdr_a: assert property (CE && rd_rise && live && auto_m && !sgl && !st.dac_rd_arm
    |=> st.sh_a[31] == st.res_pair && st.sh_a[30] == 1'b0 && st.sh_a[17:16] == 2'b00)
    else $error("dual lane auto frame malformed");
  b_float_a: assert property (CE && conv_done && live && sgl && auto_m
    |=> !RESULT_LINE_B_OE) else $error("line B still driven");
  frame4_hdr_a: assert property (CE && rd_rise && live && auto_m && sgl
    && !st.cfg[dasc_pkg::CFG_DUAL] && !st.dac_rd_arm
    |=> st.sh_a[30] == $past(st.half) && st.sh_a[17:16] == 2'b00)
    else $error("single lane auto frame malformed");
  no_dual_read_a: assert property (CE && rd_rise && live && !sgl && !st.dac_rd_arm
    |=> st.sh_a[15:0] == 16'h0) else $error("second result in dual lane mode");
  dac_frame_a: assert property (CE && rd_rise && live && st.dac_rd_arm
    |=> st.sh_a[31:28] == 4'h0 && st.sh_a[27:18] == REF_DAC_CODE && st.dac_rd_now)
    else $error("DAC readback frame wrong");
  dac_default_a: assert property ($past(RST) |-> REF_DAC_CODE == dasc_pkg::DAC_RESET)
    else $error("DAC register not at default");
  cfg_keep_a: assert property ($changed(st.pwr) |-> $stable(st.cfg))
    else $error("power change altered configuration");
  deep_abort_a: assert property ($rose(st.cfg[dasc_pkg::CFG_DEEP]) |-> !st.conv_on)
    else $error("conversion survived deep power-down");
  reset_hold_a: assert property ($past(st.rst_cnt) == '0 && st.rst_cnt != '0
    |-> st.rst_cnt == 9'(dasc_pkg::RESET_CYC) && REF_DAC_CODE == dasc_pkg::DAC_RESET)
    else $error("device reset incomplete");

endmodule

`default_nettype wire

/* File: dasc_host_model.sv */
// Host model driving the converter's serial pins and capturing the result lines
`timescale 1ns/10ps
`default_nettype none

module dasc_host_model (
  input  wire logic MCLK,
  output logic      CONV_CLK,
  output logic      SAMPLE_TRIGGER,
  output logic      READ_STROBE,
  output logic      CONFIG_SERIAL_IN,
  input  wire logic RESULT_LINE_A,
  input  wire logic RESULT_LINE_B
);
  // Half link period in MCLK cycles, kept well above the 4-cycle synchroniser delay
  localparam int HALF = 8;

  initial begin
    CONV_CLK = 1'b0;
    SAMPLE_TRIGGER = 1'b0;
    READ_STROBE = 1'b0;
    CONFIG_SERIAL_IN = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(posedge MCLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One access: strobe, n link clocks, lines sampled just before each rise
  task automatic access(input logic trig, input logic [11:0] w, input int n,
                        output logic [31:0] qa, output logic [31:0] qb);
    qa = '0;
    qb = '0;
    @(posedge MCLK);
    READ_STROBE <= 1'b1;
    SAMPLE_TRIGGER <= trig;
    CONFIG_SERIAL_IN <= w[11];
    idle(HALF);
    for (int i = 0; i < n; i++) begin
      CONV_CLK <= 1'b1;
      idle(HALF);
      CONV_CLK <= 1'b0;
      READ_STROBE <= 1'b0;
      SAMPLE_TRIGGER <= 1'b0;
      // Past the word the input toggles so stale bits cannot pass as valid
      CONFIG_SERIAL_IN <= (i < 11) ? w[10 - i] : ~CONFIG_SERIAL_IN;
      idle(HALF - 1);
      @(negedge MCLK);
      qa = {qa[30:0], RESULT_LINE_A};
      qb = {qb[30:0], RESULT_LINE_B};
      @(posedge MCLK);
    end
  endtask
endmodule

`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the dual converter serial mode control block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [7:0]  PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic        CHAN_AUTO_PIN = 1'b0;
  logic        SINGLE_OUTPUT_PIN = 1'b0;
  logic [31:0] PRDATA;
  logic        PREADY, PSLVERR, CONV_CLK, SAMPLE_TRIGGER, READ_STROBE, CONFIG_SERIAL_IN;
  logic        RESULT_LINE_A, RESULT_LINE_B, RESULT_LINE_B_OE, BUSY, ANALOG_ACTIVE;
  logic        REF_POWER_OFF;
  logic [9:0]  REF_DAC_CODE;
  logic [31:0] qa, qb, r;
  logic [11:0] a, b;
  logic [9:0]  dv;
  logic        e, p;
  int          seed, errors = 0, n_compared = 0, cycles = 0;

  always #(dasc_pkg::CLK_PERIOD_NS / 2.0) MCLK = ~MCLK;

  dasc_top dut_u (.MCLK(MCLK), .RST(RST), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CONV_CLK(CONV_CLK), .SAMPLE_TRIGGER(SAMPLE_TRIGGER),
    .READ_STROBE(READ_STROBE), .CONFIG_SERIAL_IN(CONFIG_SERIAL_IN),
    .CHAN_AUTO_PIN(CHAN_AUTO_PIN), .SINGLE_OUTPUT_PIN(SINGLE_OUTPUT_PIN),
    .RESULT_LINE_A(RESULT_LINE_A), .RESULT_LINE_B(RESULT_LINE_B),
    .RESULT_LINE_B_OE(RESULT_LINE_B_OE), .BUSY(BUSY), .ANALOG_ACTIVE(ANALOG_ACTIVE),
    .REF_POWER_OFF(REF_POWER_OFF), .REF_DAC_CODE(REF_DAC_CODE));

  dasc_host_model host_u (.MCLK(MCLK), .CONV_CLK(CONV_CLK), .SAMPLE_TRIGGER(SAMPLE_TRIGGER),
    .READ_STROBE(READ_STROBE), .CONFIG_SERIAL_IN(CONFIG_SERIAL_IN),
    .RESULT_LINE_A(RESULT_LINE_A), .RESULT_LINE_B(RESULT_LINE_B));

  ////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Model frame: two header bits, result MSB first, two zero tail bits
  function automatic logic [15:0] fr(input logic [1:0] h, input logic [11:0] v);
    return {h, v, 2'b00};
  endfunction

  // Request held until pready is seen high at a rising edge; data taken there
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50)
      errors++;
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // Loads random stand-in results, then one conversion access with input word w
  task automatic conv(input logic [11:0] w = 12'h000);
    a = 12'($random(seed));
    b = 12'($random(seed));
    apb(1'b1, dasc_pkg::ADDR_SAMPLE, {4'h0, b, 4'h0, a});
    host_u.access(1'b1, w, 16, qa, qb);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge MCLK) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      errors++;
      report_and_stop;
    end
  end

  initial begin
    seed = 69497;
    repeat (12) @(posedge MCLK);
    RST <= 1'b0;
    repeat (8) @(posedge MCLK);
    chk("dac reset", REF_DAC_CODE, 10'h3ff);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", e, 1'b1);
    apb(1'b0, dasc_pkg::ADDR_CONFIG, 32'h0);
    chk("config reset", r, 32'h0);
    // Manual, both lines; quiet input converts pair zero
    conv();
    host_u.access(1'b0, 12'h000, 16, qa, qb);
    chk("mode1 a", qa[15:0], fr(2'b00, a));
    chk("mode1 b", qb[15:0], fr(2'b00, b));
    chk("mode1 b oe", RESULT_LINE_B_OE, 1'b1);
    // DAC write then armed read; bit 9 set keeps the value word from looking like an update
    dv = {1'b1, 9'($random(seed))};
    host_u.access(1'b0, 12'h120, 16, qa, qb);
    host_u.access(1'b0, {2'b00, dv}, 16, qa, qb);
    chk("dac write", REF_DAC_CODE, dv);
    apb(1'b0, dasc_pkg::ADDR_CONFIG, 32'h0);
    chk("config update", r, 32'h120);
    host_u.access(1'b0, 12'h160, 16, qa, qb);
    host_u.access(1'b0, 12'hfff, 16, qa, qb);
    chk("dac read a", qa[15:0], {4'h0, dv, 2'b00});
    chk("dac read b", qb[15:0], fr(2'b00, b));
    chk("dac kept", REF_DAC_CODE, dv);
    // Manual, line A only with dual read; input held high converts pair one
    SINGLE_OUTPUT_PIN <= 1'b1;
    host_u.access(1'b0, 12'h101, 16, qa, qb);
    conv(12'hc00);
    apb(1'b0, dasc_pkg::ADDR_STATUS, 32'h0);
    chk("pair one", r[5], 1'b1);
    host_u.access(1'b0, 12'h000, 32, qa, qb);
    chk("mode2 dual a", qa, {fr(2'b00, a), fr(2'b01, b)});
    chk("mode2 dual b", qb[31:16], fr(2'b01, b));
    chk("mode2 b oe", RESULT_LINE_B_OE, 1'b1);
    SINGLE_OUTPUT_PIN <= 1'b0;
    host_u.access(1'b0, 12'h100, 16, qa, qb);
    // Automatic, both lines: pair alternates
    CHAN_AUTO_PIN <= 1'b1;
    p = 1'b0;
    for (int k = 0; k < 3; k++) begin
      conv();
      host_u.access(1'b0, 12'hc00, 16, qa, qb);
      chk("mode3 a", qa[15:0], fr({p, 1'b0}, a));
      chk("mode3 b", qb[15:0], fr({p, 1'b0}, b));
      p = ~p;
    end
    // Automatic, line A only: A frame then B frame, line B released
    SINGLE_OUTPUT_PIN <= 1'b1;
    conv();
    chk("mode4 b oe", RESULT_LINE_B_OE, 1'b0);
    host_u.access(1'b0, 12'h000, 16, qa, qb);
    chk("mode4 a", qa[15:0], fr({p, 1'b0}, a));
    host_u.access(1'b0, 12'h000, 16, qa, qb);
    chk("mode4 b", qa[15:0], fr({p, 1'b1}, b));
    p = ~p;
    host_u.access(1'b0, 12'h101, 16, qa, qb);
    apb(1'b0, dasc_pkg::ADDR_CONFIG, 32'h0);
    chk("dual flag", r, 32'h101);
    conv();
    host_u.access(1'b0, 12'h000, 32, qa, qb);
    chk("mode4 dual", qa, {fr({p, 1'b0}, a), fr({p, 1'b1}, b)});
    // Nap on and off; configuration survives
    host_u.access(1'b0, 12'h109, 16, qa, qb);
    host_u.idle(60);
    chk("nap off", ANALOG_ACTIVE, 1'b0);
    apb(1'b0, dasc_pkg::ADDR_CONFIG, 32'h0);
    chk("nap config", r, 32'h109);
    host_u.access(1'b0, 12'h101, 16, qa, qb);
    host_u.idle(10);
    chk("nap wake", ANALOG_ACTIVE, 1'b1);
    // Command reset restores power-up state
    host_u.access(1'b0, 12'h0a0, 16, qa, qb);
    host_u.idle(120);
    chk("cmd reset dac", REF_DAC_CODE, 10'h3ff);
    apb(1'b0, dasc_pkg::ADDR_CONFIG, 32'h0);
    chk("cmd reset cfg", r, 32'h0);
    // Deep power-down mid-conversion: result never latched, stays at reset value
    conv(12'h110);
    host_u.idle(400);
    chk("deep off", ANALOG_ACTIVE, 1'b0);
    apb(1'b0, dasc_pkg::ADDR_CONFIG, 32'h0);
    chk("deep config", r, 32'h110);
    host_u.access(1'b0, 12'h100, 16, qa, qb);
    host_u.idle(210);
    chk("deep wake", ANALOG_ACTIVE, 1'b1);
    host_u.access(1'b0, 12'h000, 16, qa, qb);
    chk("deep abort", qa[15:0], fr(2'b00, 12'h000));
    report_and_stop;
  end
endmodule

`default_nettype wire
